// >>> logic/mrd_defines.vh
`ifndef MRD_DEFINES_VH
`define MRD_DEFINES_VH
// Register indices; byte address is four times the index
`define MRD_IDX_RAMP       8'h40
`define MRD_IDX_ANALOG_MUTE      8'h41
`define MRD_IDX_DELAY      8'h42
`define MRD_IDX_DITHER     8'h43
`define MRD_IDX_VOL        8'h50
`define MRD_IDX_STATUS     8'h51
// Reset values
`define MRD_RST_RAMP       8'h10
`define MRD_RST_ANALOG_MUTE      8'h07
`define MRD_RST_DELAY      8'h19
`define MRD_RST_DITHER     8'h00
// Field positions
`define MRD_RATE_HI        7
`define MRD_RATE_LO        6
`define MRD_STEP_HI        5
`define MRD_STEP_LO        4
`define MRD_LINK_BIT       2
`define MRD_EN1_BIT        1
`define MRD_EN0_BIT        0
`define MRD_LAC_HI         7
`define MRD_LAC_LO         6
`define MRD_RAC_HI         5
`define MRD_RAC_LO         4
`define MRD_LDEM_HI        3
`define MRD_LDEM_LO        2
`define MRD_RDEM_HI        1
`define MRD_RDEM_LO        0
// Volume codes: 0x00 is +24 dB, each code is 0.5 dB down, 0xff is mute
`define MRD_VOL_MUTE       8'hff
`define MRD_VOL_UNITY      8'h30
// AXI responses
`define MRD_RESP_OKAY      2'b00
`define MRD_RESP_SLVERR    2'b10
`endif

// >>> logic/mrd_top.v
`timescale 1ns/10ps
// Notes on behaviour
// - Emergency update every 1, 2, 4 samples or instantly
// - Fault ramp uses emergency settings, not normal
// - Emergency step 4, 2, 1 or 0.5 dB
// - Zero-sample detection triggers automatic mute
// - Link bit: independent, or both channels together
// - Bit 1 enables auto mute, right channel
// - Bit 0 enables auto mute, left channel
// - Linked and one disabled: other never mutes
// - Wait programmed frame periods before analog mute
// - Left AC dither gain from bits 7-6
// - Right AC dither gain from bits 5-4
// - Left DEM dither gain from bits 3-2
// - Right DEM dither gain from bits 1-0
`include "mrd_defines.vh"
module mrd_top (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  input  wire [31:0] s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [31:0] s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire        fs_tick_in,
  input  wire        lrclk_tick_in,
  input  wire        emerg_fault_in,
  input  wire        zero_left_in,
  input  wire        zero_right_in,
  output reg         auto_mute_left_out,
  output reg         auto_mute_right_out,
  output reg  [7:0]  volume_out,
  output reg         digital_mute_done_out,
  output reg         analog_mute_out,
  output reg  [1:0]  left_primary_ac_dither_gain_out,
  output reg  [1:0]  right_primary_ac_dither_gain_out,
  output reg  [1:0]  left_primary_dem_dither_gain_out,
  output reg  [1:0]  right_primary_dem_dither_gain_out
);

  // One-hot ramp states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RAMP = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  // Rate code that skips the ramp and mutes at once
  localparam [1:0] RATE_INSTANT = 2'b11;

  reg [7:0]  ramp_ctrl_reg;
  reg [7:0]  analog_mute_ctrl_reg;
  reg [7:0]  delay_reg;
  reg [7:0]  dither_reg;
  reg [2:0]  state_reg;
  reg [2:0]  fs_cnt_reg;
  reg [7:0]  wait_cnt_reg;
  reg [31:0] awaddr_reg;
  reg        aw_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg        w_held_reg;

  wire [1:0] emerg_ramp_rate = ramp_ctrl_reg[`MRD_RATE_HI:`MRD_RATE_LO];
  wire [1:0] emerg_ramp_step = ramp_ctrl_reg[`MRD_STEP_HI:`MRD_STEP_LO];
  wire       auto_mute_link    = analog_mute_ctrl_reg[`MRD_LINK_BIT];
  wire       auto_mute_en_bit1 = analog_mute_ctrl_reg[`MRD_EN1_BIT];
  wire       auto_mute_en_bit0 = analog_mute_ctrl_reg[`MRD_EN0_BIT];

  // Word index from byte address; low two bits ignored, high addresses never alias
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      if (addr[31:10] != 22'h000000) begin
        reg_index = 8'hff;
      end else begin
        reg_index = addr[9:2];
      end
    end
  endfunction

  // Update interval in samples, from rate code
  function [2:0] rate_period;
    input [1:0] code;
    begin
      case (code)
        2'b00:   rate_period = 3'd1;
        2'b01:   rate_period = 3'd2;
        default: rate_period = 3'd4;
      endcase
    end
  endfunction

  // Step in half-dB codes, from step code
  function [7:0] step_codes;
    input [1:0] code;
    begin
      case (code)
        2'b00:   step_codes = 8'h08;
        2'b01:   step_codes = 8'h04;
        2'b10:   step_codes = 8'h02;
        default: step_codes = 8'h01;
      endcase
    end
  endfunction

  // Indices that accept writes; volume and status are read-only
  function reg_writable;
    input [7:0] idx;
    begin
      case (idx)
        `MRD_IDX_RAMP,
        `MRD_IDX_ANALOG_MUTE,
        `MRD_IDX_DELAY,
        `MRD_IDX_DITHER: reg_writable = 1'b1;
        default:         reg_writable = 1'b0;
      endcase
    end
  endfunction

  // Volume after one step; saturates so the ramp never wraps back to loud
  function [7:0] vol_after_step;
    input [7:0] vol;
    input [7:0] stp;
    reg   [8:0] sum;
    begin
      sum            = {1'b0, vol} + {1'b0, stp};
      vol_after_step = sum[8] ? `MRD_VOL_MUTE : sum[7:0];
    end
  endfunction

  // True when this sample tick completes the selected update interval
  function rate_due;
    input [2:0] cnt;
    input [1:0] code;
    begin
      rate_due = ({1'b0, cnt} + 4'd1) >= {1'b0, rate_period(code)};
    end
  endfunction

  wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  wire [7:0] wr_idx   = reg_index(awaddr_reg);
  wire [7:0] wr_byte  = wdata_reg[7:0];
  wire       wr_en    = do_write && wstrb_reg[0];
  wire       wr_hit   = reg_writable(wr_idx);

  // Write channels: address and data taken independently, then one response
  // Ready pulses once per beat; a held beat blocks a second pulse until it drains
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `MRD_RESP_OKAY;
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      awaddr_reg        <= 32'h0000_0000;
      wdata_reg         <= 32'h0000_0000;
      wstrb_reg         <= 4'h0;
    end else begin
      s_axi_awready_out <= !aw_held_reg && !s_axi_awready_out && s_axi_awvalid_in;
      s_axi_wready_out  <= !w_held_reg && !s_axi_wready_out && s_axi_wvalid_in;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata_in;
        wstrb_reg  <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_held_reg      <= 1'b0;
        w_held_reg       <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? `MRD_RESP_OKAY : `MRD_RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Control registers; DEM codes above 01 are stored as written
  // Only byte lane 0 carries a register; other lanes are dropped
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      ramp_ctrl_reg  <= `MRD_RST_RAMP;
      analog_mute_ctrl_reg <= `MRD_RST_ANALOG_MUTE;
      delay_reg      <= `MRD_RST_DELAY;
      dither_reg     <= `MRD_RST_DITHER;
    end else if (wr_en) begin
      case (wr_idx)
        `MRD_IDX_RAMP:   ramp_ctrl_reg  <= wr_byte;
        `MRD_IDX_ANALOG_MUTE:  analog_mute_ctrl_reg <= wr_byte;
        `MRD_IDX_DELAY:  delay_reg      <= wr_byte;
        `MRD_IDX_DITHER: dither_reg     <= wr_byte;
        default: ;
      endcase
    end
  end

  // Status word: ramping, auto mutes, digital done, analog mute
  wire [4:0] status_bits = {state_reg[1], auto_mute_left_out, auto_mute_right_out,
                            digital_mute_done_out, analog_mute_out};

  // Read channel: one read at a time, data registered
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `MRD_RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && s_axi_arvalid_in;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out  <= `MRD_RESP_OKAY;
        case (reg_index(s_axi_araddr_in))
          `MRD_IDX_RAMP:   s_axi_rdata_out <= {24'h000000, ramp_ctrl_reg};
          `MRD_IDX_ANALOG_MUTE:  s_axi_rdata_out <= {24'h000000, analog_mute_ctrl_reg};
          `MRD_IDX_DELAY:  s_axi_rdata_out <= {24'h000000, delay_reg};
          `MRD_IDX_DITHER: s_axi_rdata_out <= {24'h000000, dither_reg};
          `MRD_IDX_VOL:    s_axi_rdata_out <= {24'h000000, volume_out};
          `MRD_IDX_STATUS: s_axi_rdata_out <= {27'h0000000, status_bits};
          // Unmapped reads answer zero with an error
          default: begin
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `MRD_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // Auto mute: bit 0 gates left, bit 1 gates right
  wire left_cond  = zero_left_in && auto_mute_en_bit0;
  wire right_cond = zero_right_in && auto_mute_en_bit1;
  wire both_cond  = left_cond && right_cond;

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      auto_mute_left_out  <= 1'b0;
      auto_mute_right_out <= 1'b0;
    end else if (auto_mute_link) begin
      // Linked: a disabled channel blocks both
      auto_mute_left_out  <= both_cond;
      auto_mute_right_out <= both_cond;
    end else begin
      auto_mute_left_out  <= left_cond;
      auto_mute_right_out <= right_cond;
    end
  end

  // Emergency ramp and analog mute delay
  wire [7:0] step     = step_codes(emerg_ramp_step);
  wire       rate_hit = rate_due(fs_cnt_reg, emerg_ramp_rate);

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg             <= ST_IDLE;
      volume_out            <= `MRD_VOL_UNITY;
      fs_cnt_reg            <= 3'd0;
      wait_cnt_reg          <= 8'h00;
      digital_mute_done_out <= 1'b0;
      analog_mute_out       <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          digital_mute_done_out <= 1'b0;
          analog_mute_out       <= 1'b0;
          // Hold unity gain so the next fault ramps from 0 dB
          volume_out            <= `MRD_VOL_UNITY;
          fs_cnt_reg            <= 3'd0;
          // Fault ramp ignores the normal soft-mute settings
          if (emerg_fault_in) begin
            state_reg <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (emerg_ramp_rate == RATE_INSTANT) begin
            volume_out <= `MRD_VOL_MUTE;
          end else if (fs_tick_in) begin
            if (rate_hit) begin
              fs_cnt_reg <= 3'd0;
              // Saturate so the last step lands on mute
              volume_out <= vol_after_step(volume_out, step);
            end else begin
              fs_cnt_reg <= fs_cnt_reg + 3'd1;
            end
          end
          // Digital mute complete: load the drain delay
          if (volume_out == `MRD_VOL_MUTE) begin
            digital_mute_done_out <= 1'b1;
            wait_cnt_reg          <= delay_reg;
            state_reg             <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Delay lets queued samples drain before analog mute
          if (wait_cnt_reg == 8'h00) begin
            analog_mute_out <= 1'b1;
          end else if (lrclk_tick_in) begin
            wait_cnt_reg <= wait_cnt_reg - 8'h01;
          end
          // Leave only once the fault is gone and analog mute is set
          if (!emerg_fault_in && analog_mute_out) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Dither gain fields drive the modulator directly
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      left_primary_ac_dither_gain_out   <= 2'b00;
      right_primary_ac_dither_gain_out  <= 2'b00;
      left_primary_dem_dither_gain_out  <= 2'b00;
      right_primary_dem_dither_gain_out <= 2'b00;
    end else begin
      left_primary_ac_dither_gain_out   <= dither_reg[`MRD_LAC_HI:`MRD_LAC_LO];
      right_primary_ac_dither_gain_out  <= dither_reg[`MRD_RAC_HI:`MRD_RAC_LO];
      left_primary_dem_dither_gain_out  <= dither_reg[`MRD_LDEM_HI:`MRD_LDEM_LO];
      right_primary_dem_dither_gain_out <= dither_reg[`MRD_RDEM_HI:`MRD_RDEM_LO];
    end
  end

endmodule // mrd_top

// >>> dv/mrd_checker_sva.sv
`timescale 1ns/10ps
// Port-level watch on bus answers and the mute path
module mrd_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        emerg_fault_in,
  input wire logic [7:0]  volume_out,
  input wire logic        analog_mute_out,
  input wire logic        zero_left_in,
  input wire logic        zero_right_in,
  input wire logic        auto_mute_left_out,
  input wire logic        auto_mute_right_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Answers hold until taken; a read answers one cycle after its address
  property p_bhold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rhold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  property p_rlat; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  // Wrap would unmute the output, so fault ramps only climb towards mute
  property p_nowrap; emerg_fault_in && $past(emerg_fault_in) && $past(volume_out) == 8'hff |-> volume_out == 8'hff;
  endproperty
  a_nowrap: assert property (p_nowrap) else $error("volume left mute during fault");
  property p_step; emerg_fault_in && $past(emerg_fault_in) && volume_out != 8'hff
    |-> volume_out - $past(volume_out) <= 8'h08; endproperty
  a_step: assert property (p_step) else $error("ramp step too large or upward");
  property p_analog_mute; $rose(analog_mute_out) |-> volume_out == 8'hff; endproperty
  a_analog_mute: assert property (p_analog_mute) else $error("analog mute before digital mute");
  // Auto mute only follows a zero detect one cycle earlier
  property p_zl; auto_mute_left_out |-> $past(zero_left_in); endproperty
  a_zl: assert property (p_zl) else $error("left auto mute without zeros");
  property p_zr; !$past(zero_right_in) |-> !auto_mute_right_out; endproperty
  a_zr: assert property (p_zr) else $error("right auto mute without zeros");
endmodule // mrd_checker
bind mrd_top mrd_checker u_chk (.*);

// >>> dv/test_mute_ramp_dither_config.sv
`timescale 1ns/10ps
`include "mrd_defines.vh"
module test_mute_ramp_dither_config;
  logic        clk_sys_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic        s_axi_rready_in, fs_tick_in, lrclk_tick_in, emerg_fault_in, zero_left_in, zero_right_in;
  logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, left_primary_ac_dither_gain_out, right_primary_ac_dither_gain_out;
  logic [1:0]  left_primary_dem_dither_gain_out, right_primary_dem_dither_gain_out;
  logic [7:0]  volume_out;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic        auto_mute_left_out, auto_mute_right_out, digital_mute_done_out, analog_mute_out;
  int          miscompares = 0;
  int          checked = 0;
  mrd_top uut (.*);
  // System clock, 40 ns period
  always #20 clk_sys_in = ~clk_sys_in;
  task report_and_stop;
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // A spent wait bound ends the run
  task tmo(input logic spent);
    if (spent) begin
      miscompares++;
      report_and_stop;
    end
  endtask
  // One bus cycle; each channel dropped once taken, answer awaited
  task automatic axi(input logic wr, input logic [31:0] a, d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr_in <= a;
    s_axi_araddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= wr;
    s_axi_wvalid_in <= wr;
    s_axi_arvalid_in <= !wr;
    {s_axi_bready_in, s_axi_rready_in} <= {wr, !wr};
    do begin
      @(posedge clk_sys_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while ((wr ? s_axi_bvalid_out : s_axi_rvalid_out) !== 1'b1 && n < 60);
    tmo((wr ? s_axi_bvalid_out : s_axi_rvalid_out) !== 1'b1);
    chk("resp", wr ? s_axi_bresp_out : s_axi_rresp_out, er);
    if (!wr) chk("rdata", s_axi_rdata_out, d);
    {s_axi_bready_in, s_axi_rready_in} <= 2'b00;
    // An edge passes so the next call never re-raises ready in this step
    @(posedge clk_sys_in);
  endtask
  // One sample or frame tick, then time to settle
  task pulse(input logic fs);
    fs_tick_in <= fs;
    lrclk_tick_in <= !fs;
    @(posedge clk_sys_in);
    fs_tick_in <= 1'b0;
    lrclk_tick_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask
  // Reset values, unmapped and read-only places, upper bits dropped
  task regs_case;
    axi(0, 32'h100, `MRD_RST_RAMP, 2'b00);
    axi(0, 32'h104, `MRD_RST_ANALOG_MUTE, 2'b00);
    axi(0, 32'h108, 32'h19, 2'b00);
    axi(0, 32'h10c, 32'h00, 2'b00);
    axi(0, 32'h110, 32'h00, 2'b10);
    axi(1, 32'h140, 32'h12, 2'b10);
    axi(0, 32'h140, 32'h30, 2'b00);
    axi(1, 32'h108, 32'hffff_ff07, 2'b00);
    s_axi_wstrb_in <= 4'he;
    axi(1, 32'h108, 32'h55, 2'b00);
    s_axi_wstrb_in <= 4'hf;
    axi(0, 32'h108, 32'h07, 2'b00);
  endtask
  // One code walked through each gain field
  task automatic dither_case;
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      v = 8'h40 >> (2 * i);
      axi(1, 32'h10c, {24'h0, v}, 2'b00);
      repeat (2) @(posedge clk_sys_in);
      chk("lac", left_primary_ac_dither_gain_out, v[7:6]);
      chk("rac", right_primary_ac_dither_gain_out, v[5:4]);
      chk("ldem", left_primary_dem_dither_gain_out, v[3:2]);
      chk("rdem", right_primary_dem_dither_gain_out, v[1:0]);
    end
  endtask
  // Every link and enable setting against every zero pattern
  task automatic analog_mute_case;
    logic [2:0] c;
    logic [1:0] z;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      axi(1, 32'h104, {29'h0, c}, 2'b00);
      axi(0, 32'h104, {29'h0, c}, 2'b00);
      for (int j = 0; j < 4; j++) begin
        z = j[1:0];
        zero_left_in <= z[0];
        zero_right_in <= z[1];
        repeat (3) @(posedge clk_sys_in);
        chk("am_l", auto_mute_left_out, c[2] ? &{c[1:0], z} : c[0] & z[0]);
        chk("am_r", auto_mute_right_out, c[2] ? &{c[1:0], z} : c[1] & z[1]);
      end
    end
    zero_left_in <= 1'b0;
    zero_right_in <= 1'b0;
  endtask
  // Fault ramp from 0 dB: ticks to mute, then frames to analog mute
  task automatic ramp_case(input logic [1:0] r, s);
    int cnt;
    int ex;
    ex = (r == 2'b11) ? 0 : ((206 + (8 >> s)) / (8 >> s)) << r;
    axi(1, 32'h100, {24'h0, r, s, 4'h0}, 2'b00);
    axi(1, 32'h108, {30'h0, s}, 2'b00);
    emerg_fault_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    cnt = 0;
    while (volume_out !== 8'hff && cnt < 900) begin
      pulse(1'b1);
      cnt++;
    end
    tmo(volume_out !== 8'hff);
    chk("ramp", cnt, ex);
    repeat (2) @(posedge clk_sys_in);
    chk("dmute", digital_mute_done_out, 1'b1);
    cnt = 0;
    while (analog_mute_out !== 1'b1 && cnt < 300) begin
      pulse(1'b0);
      cnt++;
    end
    tmo(analog_mute_out !== 1'b1);
    chk("analog_mute", cnt, s);
    axi(0, 32'h144, 32'h03, 2'b00);
    emerg_fault_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk("idle", volume_out, 8'h30);
  endtask
  // Reset for two cycles, then each scenario in turn
  initial begin
    clk_sys_in = 1'b0;
    rst_in = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 5'h00;
    {fs_tick_in, lrclk_tick_in, emerg_fault_in, zero_left_in, zero_right_in} = 5'h00;
    {s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in} = 96'h0;
    s_axi_wstrb_in = 4'hf;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    regs_case;
    dither_case;
    analog_mute_case;
    for (int i = 0; i < 16; i++) ramp_case(i[3:2], i[1:0]);
    report_and_stop;
  end
endmodule // test_mute_ramp_dither_config
